// *** fviol_pkg.sv ***
package fviol_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int unsigned num_filters = 4;
    localparam int unsigned addr_w = 4;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [3:0] flags_offset = 4'h0;
    localparam logic [3:0] clear_offset = 4'h4;
    localparam logic [3:0] action_offset = 4'h8;
    localparam logic [3:0] mask_offset = 4'hc;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned status_lsb = 0;
    localparam int unsigned overrun_lsb = 8;
    localparam int unsigned overlap_lsb = 16;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0] flags_reset = 4'h0;
    localparam logic action_reset = 1'b0;
    localparam logic [31:0] mask_reset = 32'h0000_0000;

endpackage : fviol_pkg

// *** filter_unit_flags.sv ***
`timescale 1ns/1ps
// ****************************************
// One filter unit's sticky flags
// ****************************************
module filter_unit_flags (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Events and clear
    input wire logic perm_fail,
    input wire logic overlap_hit,
    input wire logic clear,
    // Flags and capture enable
    output logic pending,
    output logic overrun,
    output logic overlap,
    output logic capture_en
);
    typedef struct packed {
        logic pending;
        logic overrun;
        logic overlap;
    } unit_state_t;

    unit_state_t state_reg;
    unit_state_t state_next;
    logic fail;

    always_comb begin
        fail = perm_fail | overlap_hit;
        state_next = state_reg;
        // Clear first so a same-cycle event wins
        // Clear all three
        if (clear) begin
            state_next = '0;
        end
        if (fail) begin
            state_next.pending = 1'b1;
        end
        if (fail && state_reg.pending && !clear) begin
            state_next.overrun = 1'b1;
        end
        if (overlap_hit) begin
            state_next.overlap = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pending = state_reg.pending;
    assign overrun = state_reg.overrun;
    assign overlap = state_reg.overlap;
    assign capture_en = fail & ~state_reg.pending;

    a_overlap_pending: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_reg.overlap |-> state_reg.pending)
        else $error("overlap flag without pending");
    a_overrun_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        fail && state_reg.pending && !clear |=> state_reg.overrun)
        else $error("overrun not set");
endmodule : filter_unit_flags

// *** filter_violation_irq_status.sv ***
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Four filter units, one bit each in status, overrun, overlap fields.
// - Pending flags sit in bits [3:0], one per unit, 1 means asserted.
// - Permission failure or overlap error sets the unit's pending flag.
// - Flags record regardless of whether the interrupt output is enabled.
// - Overlap flag in bits [19:16] sets when two enabled regions match.
// - Overlap involving only region 0 never sets the overlap flag.
// - Setting an overlap flag also sets that unit's pending flag.
// - Overrun flag in bits [11:8] sets on a second failure before clear.
// - Clearing a unit also clears its overrun and overlap flags.
// - Status word reflects the state behind the violation interrupt.
// - Writing one to a clear bit clears the unit; clear reads zero.
// - Capture enable only while pending is clear, freezing failure info.
module filter_violation_irq_status (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Filter events
    input wire logic [3:0] perm_fail,
    input wire logic [3:0] region_match_count_ge2,
    input wire logic [3:0] region_match_only_r0,
    // Failure capture
    output logic [3:0] capture_en,
    // Interrupts
    output logic violation_irq_out,
    output logic bus_irq
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic action_irq_en;
        logic [31:0] mask;
        logic [31:0] rdata;
        logic ack;
    } top_state_t;

    top_state_t state_reg;
    top_state_t state_next;
    logic [3:0] pending;
    logic [3:0] overrun;
    logic [3:0] overlap;
    logic [3:0] overlap_hit;
    logic [3:0] clear_bits;
    logic [31:0] flags_word;
    logic wr_clear;

    function automatic logic [31:0] pack_flags(input logic [3:0] p, input logic [3:0] o,
                                               input logic [3:0] v);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[fviol_pkg::status_lsb +: 4] = p;
        w[fviol_pkg::overrun_lsb +: 4] = o;
        w[fviol_pkg::overlap_lsb +: 4] = v;
        return w;
    endfunction : pack_flags

    // ****************************************
    // Per-unit flags
    // ****************************************
    // Region 0 overlap exempt
    assign overlap_hit = region_match_count_ge2 & ~region_match_only_r0;
    assign wr_clear = write && !state_reg.ack && address == fviol_pkg::clear_offset;
    assign clear_bits = wr_clear && byteenable[0] ? writedata[3:0] : 4'h0;

    genvar g;
    generate
        for (g = 0; g < fviol_pkg::num_filters; g++) begin : g_unit
            filter_unit_flags u_flags (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .perm_fail(perm_fail[g]),
                .overlap_hit(overlap_hit[g]),
                .clear(clear_bits[g]),
                .pending(pending[g]),
                .overrun(overrun[g]),
                .overlap(overlap[g]),
                .capture_en(capture_en[g])
            );
        end
    endgenerate

    assign flags_word = pack_flags(pending, overrun, overlap);

    // ****************************************
    // Bus and registers
    // ****************************************
    // One wait cycle per access; ack ends it
    always_comb begin
        state_next = state_reg;
        state_next.ack = (read || write) && !state_reg.ack;
        if (read && !state_reg.ack) begin
            case (address)
                fviol_pkg::flags_offset: state_next.rdata = flags_word;
                fviol_pkg::clear_offset: state_next.rdata = 32'h0000_0000;
                fviol_pkg::action_offset: state_next.rdata = {31'h0, state_reg.action_irq_en};
                fviol_pkg::mask_offset: state_next.rdata = state_reg.mask;
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end
        if (write && !state_reg.ack) begin
            case (address)
                fviol_pkg::action_offset: begin
                    if (byteenable[0]) begin
                        state_next.action_irq_en = writedata[0];
                    end
                end
                fviol_pkg::mask_offset: begin
                    for (int b = 0; b < 4; b++) begin
                        if (byteenable[b]) begin
                            state_next.mask[b*8 +: 8] = writedata[b*8 +: 8];
                        end
                    end
                end
                default: state_next.action_irq_en = state_reg.action_irq_en;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg.action_irq_en <= fviol_pkg::action_reset;
            state_reg.mask <= fviol_pkg::mask_reset;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.ack <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign waitrequest = (read || write) && !state_reg.ack;
    assign readdata = state_reg.rdata;

    // ****************************************
    // Interrupt outputs
    // ****************************************
    // Action gates only the pin
    assign violation_irq_out = (|pending) && state_reg.action_irq_en;
    // Software mask view over the same sticky word
    assign bus_irq = |(flags_word & state_reg.mask);

    a_irq_pin: assert property (@(posedge ref_clk) disable iff (!nrst)
        violation_irq_out == ((|pending) && state_reg.action_irq_en))
        else $error("interrupt pin mismatch");
    a_fail_sets: assert property (@(posedge ref_clk) disable iff (!nrst)
        perm_fail[0] |=> pending[0])
        else $error("pending not set on failure");
    a_flag_noen: assert property (@(posedge ref_clk) disable iff (!nrst)
        !state_reg.action_irq_en && overlap_hit[1] |=> pending[1] && overlap[1])
        else $error("flags depend on action");
    a_r0_exempt: assert property (@(posedge ref_clk) disable iff (!nrst)
        region_match_only_r0[2] && !overlap[2] && !clear_bits[2] |=> !overlap[2])
        else $error("region 0 overlap flagged");
    a_clear_all: assert property (@(posedge ref_clk) disable iff (!nrst)
        clear_bits[3] && !perm_fail[3] && !overlap_hit[3] |=> !pending[3] && !overrun[3]
        && !overlap[3])
        else $error("clear incomplete");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        (flags_word & 32'hfff0_f0f0) == 32'h0000_0000)
        else $error("reserved bits set");
    a_clear_rdzero: assert property (@(posedge ref_clk) disable iff (!nrst)
        read && !state_reg.ack && address == fviol_pkg::clear_offset |=> readdata == 32'h0)
        else $error("clear read nonzero");
    a_capture_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        pending[0] |-> !capture_en[0])
        else $error("capture while pending");

    // ****************************************
    // Clear path sequences
    // ****************************************
    // Clear request for unit 1 on the first bus cycle
    sequence s_clear_unit1;
        write && !state_reg.ack && address == fviol_pkg::clear_offset && byteenable[0]
            && writedata[1];
    endsequence
    // No new failure at unit 1 in the same cycle
    sequence s_unit1_quiet;
        !perm_fail[1] && !overlap_hit[1];
    endsequence
    a_clear_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_clear_unit1 and s_unit1_quiet |=> !pending[1] && !overrun[1] && !overlap[1])
        else $error("clear write left flags set");
    a_set_wins: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_clear_unit1 and perm_fail[1] |=> pending[1])
        else $error("failure lost to clear");
endmodule : filter_violation_irq_status

// *** irq_sink.sv ***
`timescale 1ns/1ps
// ****************************************
// Interrupt controller stand-in
// ****************************************
module irq_sink (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Level interrupt
    input wire logic irq,
    // Rising edges seen
    output logic [7:0] rise_cnt
);
    logic irq_reg;
    // Sampled on the clock, so a glitch between rising edges never counts
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
            rise_cnt <= 8'h00;
        end else begin
            irq_reg <= irq;
            if (irq && !irq_reg) begin
                rise_cnt <= rise_cnt + 8'h01;
            end
        end
    end
endmodule : irq_sink

// *** filter_violation_irq_status_bench.sv ***
`timescale 1ns/1ps
module filter_violation_irq_status_bench;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    logic [3:0] perm_fail = 4'h0;
    logic [3:0] ge2 = 4'h0;
    logic [3:0] only_r0 = 4'h0;
    logic [3:0] capture_en;
    logic violation_irq_out;
    logic bus_irq;
    logic [7:0] rise_cnt;
    logic [31:0] q;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    always #2 ref_clk = ~ref_clk;
    filter_violation_irq_status i_filter_violation_irq_status (.ref_clk, .nrst, .address,
        .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .perm_fail,
        .region_match_count_ge2(ge2), .region_match_only_r0(only_r0), .capture_en,
        .violation_irq_out, .bus_irq);
    irq_sink i_irq_sink (.ref_clk, .nrst, .irq(violation_irq_out), .rise_cnt);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        // Sampled at the rising edge; data and release belong to that same edge
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic ev(input logic [3:0] f, input logic [3:0] g, input logic [3:0] z,
        input logic [3:0] cap);
        @(posedge ref_clk);
        perm_fail <= f;
        ge2 <= g;
        only_r0 <= z;
        @(negedge ref_clk);
        if (f !== 4'h0) chk({28'h0, capture_en}, {28'h0, cap});
        @(posedge ref_clk);
        perm_fail <= 4'h0;
        ge2 <= 4'h0;
        only_r0 <= 4'h0;
    endtask : ev
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task automatic t_reset;
        bus(1'b0, fviol_pkg::flags_offset, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, fviol_pkg::clear_offset, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, violation_irq_out}, 32'h0);
    endtask : t_reset
    // Two failures at unit 0 with the interrupt disabled
    task automatic t_perm;
        ev(4'h1, 4'h0, 4'h0, 4'h1);
        ev(4'h1, 4'h0, 4'h0, 4'h0);
        bus(1'b0, fviol_pkg::flags_offset, 32'h0);
        chk(q, (32'h1 << fviol_pkg::status_lsb) | (32'h1 << fviol_pkg::overrun_lsb));
        chk({31'h0, violation_irq_out}, 32'h0);
    endtask : t_perm
    task automatic t_overlap;
        ev(4'h0, 4'h4, 4'h4, 4'h0);
        bus(1'b0, fviol_pkg::flags_offset, 32'h0);
        chk(q, 32'h0000_0101);
        ev(4'h0, 4'h4, 4'h0, 4'h0);
        bus(1'b0, fviol_pkg::flags_offset, 32'h0);
        chk(q, 32'h101 | (32'h4 << fviol_pkg::overlap_lsb) | 32'h4);
    endtask : t_overlap
    // Every unit fails at once; units 0 and 2 overrun
    task automatic t_all;
        ev(4'hf, 4'h0, 4'h0, 4'ha);
        bus(1'b0, fviol_pkg::flags_offset, 32'h0);
        chk(q, 32'hf | (32'h5 << fviol_pkg::overrun_lsb) | (32'h4 << fviol_pkg::overlap_lsb));
        bus(1'b1, fviol_pkg::flags_offset, 32'hffff_ffff);
        bus(1'b0, fviol_pkg::flags_offset, 32'h0);
        chk(q, 32'h0004_050f);
        chk({31'h0, bus_irq}, 32'h0);
    endtask : t_all
    task automatic t_irq;
        bus(1'b1, fviol_pkg::mask_offset, 32'h1);
        chk({31'h0, bus_irq}, 32'h1);
        bus(1'b1, fviol_pkg::action_offset, 32'h1);
        chk({31'h0, violation_irq_out}, 32'h1);
        // Sink counts the edge on the next clock
        @(negedge ref_clk);
        chk({24'h0, rise_cnt}, 32'h1);
        bus(1'b1, fviol_pkg::clear_offset, 32'h5);
        bus(1'b0, fviol_pkg::flags_offset, 32'h0);
        chk(q, 32'ha);
        chk({31'h0, bus_irq}, 32'h0);
        bus(1'b1, fviol_pkg::clear_offset, 32'ha);
        chk({31'h0, violation_irq_out}, 32'h0);
        ev(4'h1, 4'h0, 4'h0, 4'h1);
        bus(1'b0, fviol_pkg::flags_offset, 32'h0);
        chk(q, 32'h1);
        @(negedge ref_clk);
        chk({24'h0, rise_cnt}, 32'h2);
    endtask : t_irq
    // Ceiling well above the fewer than a hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset();
        t_perm();
        t_overlap();
        t_all();
        t_irq();
        test_done();
    end
endmodule : filter_violation_irq_status_bench
